// ---- src/ulmcs_defs.vh ----
// Purpose: constants for the serial line control and status block
// Assumes: AHB-Lite slave with word-aligned 8-bit registers
// Notes:   offsets are byte addresses (index times four)
`ifndef ULMCS_DEFS_VH
`define ULMCS_DEFS_VH
// register indices
`define ULMCS_IDX_DATA      3'h0
`define ULMCS_IDX_IER       3'h1
`define ULMCS_IDX_FCTL      3'h2
`define ULMCS_IDX_LFC       3'h3
`define ULMCS_IDX_MHC       3'h4
`define ULMCS_IDX_LCF       3'h5
`define ULMCS_IDX_MSTAT     3'h6
// line format fields
`define ULMCS_LFC_STOP      2
`define ULMCS_LFC_PEN       3
`define ULMCS_LFC_EPS       4
`define ULMCS_LFC_STICK     5
`define ULMCS_LFC_BRK       6
`define ULMCS_LFC_DIVISOR_ACCESS_SELECT      7
// modem control fields
`define ULMCS_MHC_DTR       0
`define ULMCS_MHC_RTS       1
`define ULMCS_MHC_AUX_OUTPUT_ONE      2
`define ULMCS_MHC_AUX_OUTPUT_TWO_IRQ_GATE      3
`define ULMCS_MHC_LOOP      4
// reset values
`define ULMCS_LFC_RST       8'h03
`define ULMCS_MHC_RST       5'h00
`define ULMCS_DIV_RST       16'h0001
// receive fifo depth
`define ULMCS_FIFO_DEPTH    16
`define ULMCS_FIFO_AW       4
`endif

// ---- src/ulmcs_tx.v ----
// Purpose: serial transmitter shifting one framed character
// Assumes: tick is one pulse per sixteenth of a bit
// Notes:   parity and stop length follow the format inputs
`timescale 1ns/1ns
module ulmcs_tx (
    input  wire       hclk,
    input  wire       hresetn,
    input  wire       tick,
    input  wire       load,
    input  wire [7:0] data,
    input  wire [7:0] fmt,
    output wire       busy,
    output reg        txd_r
);
`include "ulmcs_defs.vh"
    localparam ST_IDLE = 2'd0;
    localparam ST_SHFT = 2'd1;
    localparam ST_STOP = 2'd2;

    reg [1:0]  state_r;
    reg [10:0] sh_r;
    reg [3:0]  nbits_r;
    reg [3:0]  sub_r;
    reg [5:0]  stop_r;
    reg [5:0]  stop_len;
    reg [3:0]  dlen;
    reg        par;
    reg [7:0]  dmask;
    reg [10:0] frame;

    assign busy = (state_r != ST_IDLE);

    // frame layout from format bits
    always @* begin
        dlen  = 4'd5 + {2'b00, fmt[1:0]};
        dmask = 8'hff >> (3'd3 - {1'b0, fmt[1:0]});
        par   = ~(^(data & dmask)) ^ fmt[`ULMCS_LFC_EPS];
        if (fmt[`ULMCS_LFC_STICK])
            par = ~fmt[`ULMCS_LFC_EPS];
        if (!fmt[`ULMCS_LFC_STOP])
            stop_len = 6'd16;
        else if (fmt[1:0] == 2'b00)
            stop_len = 6'd24;
        else
            stop_len = 6'd32;
        // start low, data lsb first, marks above
        frame = (11'h7ff << (dlen + 4'd1)) | {2'b00, data & dmask, 1'b0};
        if (fmt[`ULMCS_LFC_PEN])
            frame[dlen + 4'd1] = par;
    end

    // shift out start, data, parity, then hold stop level
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_IDLE;
            sh_r    <= 11'h7ff;
            nbits_r <= 4'h0;
            sub_r   <= 4'h0;
            stop_r  <= 6'h00;
            txd_r   <= 1'b1;
        end else begin
            case (state_r)
            ST_IDLE: begin
                txd_r <= 1'b1;
                if (load) begin
                    // start bit, data lsb first, parity after last data
                    sh_r    <= frame;
                    nbits_r <= dlen + {3'b000, fmt[`ULMCS_LFC_PEN]} + 4'd1;
                    sub_r   <= 4'h0;
                    state_r <= ST_SHFT;
                end
            end
            ST_SHFT: begin
                txd_r <= sh_r[0];
                if (tick) begin
                    sub_r <= sub_r + 4'd1;
                    if (sub_r == 4'hf) begin
                        sh_r    <= {1'b1, sh_r[10:1]};
                        nbits_r <= nbits_r - 4'd1;
                        if (nbits_r == 4'd1) begin
                            state_r <= ST_STOP;
                            stop_r  <= 6'h00;
                        end
                    end
                end
            end
            default: begin
                txd_r <= 1'b1;
                if (tick) begin
                    stop_r <= stop_r + 6'd1;
                    if (stop_r == stop_len - 6'd1)
                        state_r <= ST_IDLE;
                end
            end
            endcase
        end
    end
endmodule // ulmcs_tx

// ---- src/ulmcs_rx.v ----
// Purpose: serial receiver with parity, framing and break checks
// Assumes: tick is one pulse per sixteenth of a bit
// Notes:   only the first stop bit is checked
`timescale 1ns/1ns
module ulmcs_rx (
    input  wire       hclk,
    input  wire       hresetn,
    input  wire       tick,
    input  wire       rxd,
    input  wire [7:0] fmt,
    output reg        done_r,
    output reg  [7:0] data_r,
    output reg        perr_r,
    output reg        ferr_r,
    output reg        brk_r
);
`include "ulmcs_defs.vh"
    localparam ST_IDLE = 2'd0;
    localparam ST_BITS = 2'd1;
    localparam ST_WAIT = 2'd2;

    reg [1:0] state_r;
    reg [3:0] sub_r;
    reg [3:0] idx_r;
    reg [9:0] sh_r;
    reg       allz_r;
    reg [3:0] dlen;
    reg [3:0] last;
    reg       pexp;

    // expected parity and frame length
    always @* begin
        dlen = 4'd5 + {2'b00, fmt[1:0]};
        last = dlen + {3'b000, fmt[`ULMCS_LFC_PEN]};
        pexp = ~(^(sh_r[7:0] & (8'hff >> (3'd3 - {1'b0, fmt[1:0]}))))
               ^ fmt[`ULMCS_LFC_EPS];
        if (fmt[`ULMCS_LFC_STICK])
            pexp = ~fmt[`ULMCS_LFC_EPS];
    end

    // sample mid-bit; idx 0 is start, then data, parity, first stop
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_IDLE;
            sub_r   <= 4'h0;
            idx_r   <= 4'h0;
            sh_r    <= 10'h000;
            allz_r  <= 1'b0;
            done_r  <= 1'b0;
            data_r  <= 8'h00;
            perr_r  <= 1'b0;
            ferr_r  <= 1'b0;
            brk_r   <= 1'b0;
        end else begin
            done_r <= 1'b0;
            case (state_r)
            ST_IDLE: begin
                if (tick && !rxd) begin
                    state_r <= ST_BITS;
                    sub_r   <= 4'h1;
                    idx_r   <= 4'h0;
                    allz_r  <= 1'b1;
                end
            end
            ST_BITS: begin
                if (tick) begin
                    sub_r <= sub_r + 4'd1;
                    if (sub_r == 4'h7) begin
                        allz_r <= allz_r & ~rxd;
                        if (idx_r == 4'h0 && rxd) begin
                            state_r <= ST_IDLE;                   // glitch, not a start
                        end else if (idx_r == last + 4'd1) begin
                            // first stop bit only
                            data_r  <= sh_r[7:0] & (8'hff >> (3'd3 - {1'b0, fmt[1:0]}));
                            perr_r  <= fmt[`ULMCS_LFC_PEN] & (sh_r[dlen] != pexp);
                            ferr_r  <= ~rxd;
                            brk_r   <= allz_r & ~rxd;
                            done_r  <= 1'b1;
                            if (allz_r & ~rxd) begin
                                state_r <= ST_WAIT;
                                sub_r   <= 4'h0;
                            end else if (!rxd) begin
                                // stop read low: take it as next start
                                idx_r  <= 4'h0;
                                sub_r  <= 4'h8;
                                allz_r <= 1'b1;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end else begin
                            if (idx_r != 4'h0)
                                sh_r[idx_r - 4'd1] <= rxd;
                            idx_r <= idx_r + 4'd1;
                        end
                    end
                end
            end
            default: begin
                // after break, need half a bit of mark
                if (rxd) begin
                    if (tick) begin
                        sub_r <= sub_r + 4'd1;
                        if (sub_r == 4'h7)
                            state_r <= ST_IDLE;
                    end
                end else begin
                    sub_r <= 4'h0;
                end
            end
            endcase
        end
    end
endmodule // ulmcs_rx

// ---- src/ulmcs_top.v ----
// Purpose: line format, modem control and line status with an AHB-Lite slave
// Assumes: one clock; serial and modem inputs synchronous to hclk
// Notes:   baud divisor gives sixteen ticks per bit
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ns
`include "ulmcs_defs.vh"
module ulmcs_top (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire        rxd,
    output wire        txd,
    input  wire        clear_send_in_n,
    input  wire        set_ready_in_n,
    input  wire        ring_in_n,
    input  wire        carrier_detect_in_n,
    output wire        terminal_ready_out_n,
    output wire        request_send_out_n,
    output wire        irq_o,
    output wire        irq_oe_n
);
    // register state
    reg [7:0]  line_format_control_r;
    reg [4:0]  modem_handshake_control_r;
    reg [15:0] div_r;
    reg [3:0]  ier_r;
    reg        fifo_en_r;
    reg        ovr_r;
    reg        lsr_perr_r;
    reg        lsr_ferr_r;
    reg        lsr_brk_r;
    reg [7:0]  tx_holding_reg_r;
    reg        tx_holding_empty_r;
    reg        tx_load_r;
    reg [15:0] baud_cnt_r;
    reg        tick_r;
    reg [3:0]  msr_prev_r;
    reg [3:0]  msr_delta_r;
    // receive fifo: data plus three error bits each
    reg [10:0] rx_mem [0:`ULMCS_FIFO_DEPTH-1];
    reg [`ULMCS_FIFO_AW-1:0] rd_ptr_r;
    reg [`ULMCS_FIFO_AW-1:0] wr_ptr_r;
    reg [`ULMCS_FIFO_AW:0]   cnt_r;
    reg [4:0]  err_cnt_r;
    reg        head_seen_r;
    // address phase capture
    reg        dp_valid_r;
    reg        dp_write_r;
    reg [2:0]  dp_idx_r;

    wire       divisor_access_select      = line_format_control_r[`ULMCS_LFC_DIVISOR_ACCESS_SELECT];
    wire       loop      = modem_handshake_control_r[`ULMCS_MHC_LOOP];
    wire       tx_busy;
    wire       tx_ser;
    wire       rx_done;
    wire [7:0] rx_data;
    wire       rx_perr;
    wire       rx_ferr;
    wire       rx_brk;
    wire       depth_lim = fifo_en_r ? (cnt_r == `ULMCS_FIFO_DEPTH) : (cnt_r != 5'd0);
    wire       rx_avail  = (cnt_r != 5'd0);
    wire [10:0] head     = rx_mem[rd_ptr_r];
    wire       wr_ok     = dp_valid_r & dp_write_r;
    wire       rd_ok     = dp_valid_r & ~dp_write_r;

    // bus decode helper
    function [2:0] word_index;
        input [31:0] a;
        begin
            word_index = a[4:2];
        end
    endfunction

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // address phase: single-cycle answer, zero wait states
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_r <= 1'b0;
            dp_write_r <= 1'b0;
            dp_idx_r   <= 3'h0;
        end else if (hready) begin
            dp_valid_r <= hsel & htrans[1];
            dp_write_r <= hwrite;
            dp_idx_r   <= word_index(haddr);
        end
    end

    // access strobes; low offsets depend on divisor access
    wire wr_thr  = wr_ok & (dp_idx_r == `ULMCS_IDX_DATA) & ~divisor_access_select;
    wire rd_rbr  = rd_ok & (dp_idx_r == `ULMCS_IDX_DATA) & ~divisor_access_select;
    wire rd_lsr  = rd_ok & (dp_idx_r == `ULMCS_IDX_LCF);
    wire rd_msr  = rd_ok & (dp_idx_r == `ULMCS_IDX_MSTAT);
    wire pop     = rd_rbr & rx_avail;
    // without fifo a new character replaces the unread one
    wire push    = rx_done & (~depth_lim | (~fifo_en_r & pop));
    wire overwr  = rx_done & ~fifo_en_r & rx_avail & ~pop;

    // modem inputs, or control bits in loopback
    wire [3:0] modem_now = loop ? {modem_handshake_control_r[3], modem_handshake_control_r[2],
                                   modem_handshake_control_r[0], modem_handshake_control_r[1]}
                                : {~carrier_detect_in_n, ~ring_in_n,
                                   ~set_ready_in_n, ~clear_send_in_n};

    // line status image
    wire [7:0] lsr_val = {fifo_en_r & (err_cnt_r != 5'd0),
                          tx_holding_empty_r & ~tx_busy & ~tx_load_r,
                          tx_holding_empty_r,
                          lsr_brk_r, lsr_ferr_r, lsr_perr_r, ovr_r,
                          rx_avail};

    // read data mux, combinational from the index captured at address phase end
    always @* begin
        hrdata = 32'h0000_0000;
        if (dp_valid_r && !dp_write_r) begin
            if (dp_idx_r == `ULMCS_IDX_DATA)
                hrdata[7:0] = divisor_access_select ? div_r[7:0] : head[7:0];
            else if (dp_idx_r == `ULMCS_IDX_IER)
                hrdata[7:0] = divisor_access_select ? div_r[15:8] : {4'h0, ier_r};
            else if (dp_idx_r == `ULMCS_IDX_FCTL)
                hrdata[7:0] = {fifo_en_r, fifo_en_r, 6'h00};
            else if (dp_idx_r == `ULMCS_IDX_LFC)
                hrdata[7:0] = line_format_control_r;
            else if (dp_idx_r == `ULMCS_IDX_MHC)
                hrdata[7:0] = {3'b000, modem_handshake_control_r};
            else if (dp_idx_r == `ULMCS_IDX_LCF)
                hrdata[7:0] = lsr_val;
            else if (dp_idx_r == `ULMCS_IDX_MSTAT)
                hrdata[7:0] = {modem_now, msr_delta_r};
            else
                hrdata = 32'h0000_0000;
        end
    end

    // control registers written by software
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_format_control_r     <= `ULMCS_LFC_RST;
            modem_handshake_control_r <= `ULMCS_MHC_RST;
            div_r                     <= `ULMCS_DIV_RST;
            ier_r                     <= 4'h0;
            fifo_en_r                 <= 1'b0;
        end else if (wr_ok) begin
            if (dp_idx_r == `ULMCS_IDX_DATA && divisor_access_select)
                div_r[7:0] <= hwdata[7:0];
            else if (dp_idx_r == `ULMCS_IDX_IER && divisor_access_select)
                div_r[15:8] <= hwdata[7:0];
            else if (dp_idx_r == `ULMCS_IDX_IER)
                ier_r <= hwdata[3:0];
            else if (dp_idx_r == `ULMCS_IDX_FCTL)
                fifo_en_r <= hwdata[0];
            else if (dp_idx_r == `ULMCS_IDX_LFC)
                line_format_control_r <= hwdata[7:0];
            else if (dp_idx_r == `ULMCS_IDX_MHC)
                modem_handshake_control_r <= hwdata[4:0];
        end
    end

    // sixteen ticks per bit from the divisor
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            baud_cnt_r <= 16'h0000;
            tick_r     <= 1'b0;
        end else if (baud_cnt_r >= div_r - 16'd1) begin
            baud_cnt_r <= 16'h0000;
            tick_r     <= 1'b1;
        end else begin
            baud_cnt_r <= baud_cnt_r + 16'd1;
            tick_r     <= 1'b0;
        end
    end

    // holding register and hand-off to the shifter
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_holding_reg_r   <= 8'h00;
            tx_holding_empty_r <= 1'b1;
            tx_load_r          <= 1'b0;
        end else begin
            tx_load_r <= 1'b0;
            if (wr_thr) begin
                tx_holding_reg_r   <= hwdata[7:0];
                tx_holding_empty_r <= 1'b0;
            end else if (!tx_holding_empty_r && !tx_busy && !tx_load_r) begin
                tx_load_r          <= 1'b1;
                tx_holding_empty_r <= 1'b1;
            end
        end
    end

    ulmcs_tx u_tx (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tick    (tick_r),
        .load    (tx_load_r),
        .data    (tx_holding_reg_r),
        .fmt     (line_format_control_r),
        .busy    (tx_busy),
        .txd_r   (tx_ser)
    );

    // receiver input: looped transmitter or pin
    ulmcs_rx u_rx (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tick    (tick_r),
        .rxd     (loop ? tx_ser : rxd),
        .fmt     (line_format_control_r),
        .done_r  (rx_done),
        .data_r  (rx_data),
        .perr_r  (rx_perr),
        .ferr_r  (rx_ferr),
        .brk_r   (rx_brk)
    );

    // receive buffer: depth one without fifo mode, full depth with it
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ptr_r  <= {`ULMCS_FIFO_AW{1'b0}};
            wr_ptr_r  <= {`ULMCS_FIFO_AW{1'b0}};
            cnt_r     <= 5'd0;
            err_cnt_r <= 5'd0;
        end else if (wr_ok && dp_idx_r == `ULMCS_IDX_FCTL && !hwdata[0]) begin
            rd_ptr_r  <= {`ULMCS_FIFO_AW{1'b0}};
            wr_ptr_r  <= {`ULMCS_FIFO_AW{1'b0}};
            cnt_r     <= 5'd0;
            err_cnt_r <= 5'd0;
        end else begin
            if (push) begin
                rx_mem[wr_ptr_r] <= {rx_brk, rx_ferr, rx_perr,
                                     rx_brk ? 8'h00 : rx_data};
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end else if (overwr) begin
                rx_mem[rd_ptr_r] <= {rx_brk, rx_ferr, rx_perr,
                                     rx_brk ? 8'h00 : rx_data};
            end
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
            cnt_r <= cnt_r + {4'd0, push} - {4'd0, pop};
            err_cnt_r <= err_cnt_r
                         + {4'd0, (push | overwr) & (rx_brk | rx_ferr | rx_perr)}
                         - {4'd0, (pop | overwr) & (|head[10:8])};
        end
    end

    // error flags: set beats the read that clears
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovr_r      <= 1'b0;
            lsr_perr_r <= 1'b0;
            lsr_ferr_r <= 1'b0;
            lsr_brk_r  <= 1'b0;
            head_seen_r <= 1'b0;
        end else begin
            ovr_r <= (rx_done & depth_lim) | (ovr_r & ~rd_lsr);
            // head errors latched once per character, so a read clears them
            head_seen_r <= rx_avail & ~pop & ~overwr;
            lsr_perr_r <= (rx_avail & ~head_seen_r & head[8] & ~pop)
                          | (lsr_perr_r & ~rd_lsr);
            lsr_ferr_r <= (rx_avail & ~head_seen_r & head[9] & ~pop)
                          | (lsr_ferr_r & ~rd_lsr);
            lsr_brk_r  <= (rx_avail & ~head_seen_r & head[10] & ~pop)
                          | (lsr_brk_r & ~rd_lsr);
        end
    end

    // modem status change tracking
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            msr_prev_r  <= 4'h0;
            msr_delta_r <= 4'h0;
        end else begin
            msr_prev_r  <= modem_now;
            msr_delta_r <= ({modem_now[3] ^ msr_prev_r[3], ~modem_now[2] & msr_prev_r[2],
                             modem_now[1:0] ^ msr_prev_r[1:0]})
                           | (msr_delta_r & {4{~rd_msr}});
        end
    end

    // interrupt sources, each gated by its enable
    wire line_irq  = ier_r[2] & (ovr_r | lsr_perr_r | lsr_ferr_r | lsr_brk_r);
    wire any_irq   = line_irq | (ier_r[0] & rx_avail)
                     | (ier_r[1] & tx_holding_empty_r)
                     | (ier_r[3] & (|msr_delta_r));

    // interrupt pin released unless aux output two set
    assign irq_o    = any_irq;
    assign irq_oe_n = ~modem_handshake_control_r[`ULMCS_MHC_AUX_OUTPUT_TWO_IRQ_GATE];

    // serial output: break over loopback over data
    assign txd = line_format_control_r[`ULMCS_LFC_BRK] ? 1'b0 : (loop ? 1'b1 : tx_ser);

    // handshake pins, forced high in loopback
    assign terminal_ready_out_n = loop | ~modem_handshake_control_r[`ULMCS_MHC_DTR];
    assign request_send_out_n   = loop | ~modem_handshake_control_r[`ULMCS_MHC_RTS];
endmodule // ulmcs_top

// ---- dv/ulmcs_chk.sv ----
// Purpose: port checks for ulmcs_top
// Assumes: shadows follow host writes
// Notes:   bound at the foot
`timescale 1ns/1ns
module ulmcs_chk (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        hreadyout,
    input wire [31:0] hrdata,
    input wire        txd,
    input wire        terminal_ready_out_n,
    input wire        request_send_out_n,
    input wire        irq_oe_n
);
    reg       wv_r;
    reg       rv_r;
    reg [2:0] a_r;
    reg [7:0] mc_r;
    reg [7:0] lf_r;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // shadow line format and modem control
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wv_r <= 1'b0;
            rv_r <= 1'b0;
            a_r  <= 3'h0;
            mc_r <= 8'h00;
            lf_r <= 8'h03;
        end else begin
            wv_r <= hsel & htrans[1] & hready & hwrite;
            rv_r <= hsel & htrans[1] & hready & !hwrite;
            a_r  <= haddr[4:2];
            if (wv_r && a_r == 3'h4) mc_r <= hwdata[7:0];
            if (wv_r && a_r == 3'h3) lf_r <= hwdata[7:0];
        end
    end
    a_ready_high: assert property (hreadyout) else $error("wait state");
    a_rdata_upper: assert property (rv_r |-> hrdata[31:8] == 24'h0) else $error("upper data");
    a_ctl_zero: assert property (rv_r && a_r == 3'h4 |-> hrdata[7:5] == 3'h0)
        else $error("control top bits");
    a_term_pin: assert property (terminal_ready_out_n == (mc_r[4] | !mc_r[0]))
        else $error("terminal ready pin");
    a_req_pin: assert property (request_send_out_n == (mc_r[4] | !mc_r[1]))
        else $error("request pin");
    a_irq_gate: assert property (!mc_r[4] |-> irq_oe_n == !mc_r[3])
        else $error("irq gate");
    a_break_low: assert property (lf_r[6] && !mc_r[4] |-> !txd)
        else $error("break level");
    a_loop_mark: assert property (mc_r[4] && !lf_r[6] |-> txd)
        else $error("loop mark");
endmodule // ulmcs_chk
bind ulmcs_top ulmcs_chk u_ulmcs_chk (.*);

// ---- dv/ulmcs_peer.sv ----
// Purpose: serial far end for ulmcs_top tests
// Assumes: BIT cycles per bit, lsb first
// Notes:   line marks when idle
`timescale 1ns/1ns
module ulmcs_peer #(parameter int BIT = 16) (
    input  wire  hclk,
    input  wire  txd,
    output logic rxd = 1'b1
);
    // drive n frame bits, then mark
    task automatic send(input logic [11:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            rxd <= f[i];
            repeat (BIT) @(posedge hclk);
        end
        rxd <= 1'b1;
    endtask
    // find start edge, sample mid-bit
    task automatic grab(output logic [11:0] f, input int n);
        int t;
        t = 0;
        f = 12'h000;
        while (txd !== 1'b0 && t < 3000) begin
            @(posedge hclk);
            t++;
        end
        repeat (BIT / 2) @(posedge hclk);
        for (int i = 0; i < n; i++) begin
            f[i] = txd;
            repeat (BIT) @(posedge hclk);
        end
    endtask
endmodule // ulmcs_peer

// ---- dv/test_ulmcs_top.sv ----
// Purpose: register, serial and loop tests
// Assumes: divisor one, sixteen cycles a bit
// Notes:   modem inputs held inactive
`timescale 1ns/1ns
module test_ulmcs_top;
    logic        hclk = 1'b0;
    logic        hresetn, hsel, hwrite, hreadyout, hresp, txd, rxd, td_n, rq_n, irq, irq_oe_n;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [11:0] f, e;
    logic [7:0]  q, l, m;
    logic [7:0]  fm [4] = '{8'h03, 8'h1a, 8'h09, 8'h38};
    int          mismatches = 0, num_checks = 0, nb;
    always #4 hclk = ~hclk;
    ulmcs_top u_ulmcs_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxd(rxd), .txd(txd),
        .clear_send_in_n(1'b1), .set_ready_in_n(1'b1), .ring_in_n(1'b1),
        .carrier_detect_in_n(1'b1), .terminal_ready_out_n(td_n), .request_send_out_n(rq_n),
        .irq_o(irq), .irq_oe_n(irq_oe_n));
    ulmcs_peer u_ulmcs_peer (.hclk(hclk), .txd(txd), .rxd(rxd));
    // one bus transfer, read data taken at the closing edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        int t;
        t = 0;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do begin @(posedge hclk); t++; end while (hreadyout !== 1'b1 && t < 50);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do begin @(posedge hclk); t++; end while (hreadyout !== 1'b1 && t < 99);
        q = hrdata[7:0];
        if (t > 98) begin mismatches++; close_out(); end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
        #1;
    endtask
    task automatic chk(input logic [11:0] g, input logic [11:0] x);
        num_checks++;
        if (g !== x) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] x);
        bus(a, 1'b0, 8'h00);
        chk({4'h0, q}, {4'h0, x});
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(8'h0c, 8'h03);
        rdc(8'h1c, 8'h00);
        wr(8'h10, 8'hff);
        rdc(8'h10, 8'h1f);
        chk({td_n, rq_n}, 12'h3);
        wr(8'h10, 8'h0b);
        chk({irq_oe_n, td_n, rq_n}, 12'h0);
        wr(8'h10, 8'h01);
        chk({irq_oe_n, td_n, rq_n}, 12'h5);
        wr(8'h0c, 8'h83);
        wr(8'h00, 8'h01);
        rdc(8'h00, 8'h01);
        wr(8'h0c, 8'h43);
        chk(txd, 12'h0);
        $display("regs done");
        for (int k = 0; k < 4; k++) begin
            l = fm[k];
            nb = 7 + l[1:0] + l[3];
            m = (8'h6d + k) & ~(8'hff << (5 + l[1:0]));
            e = {4'h0, m} << 1;
            e[6 + l[1:0]] = l[3] & (l[5] ? !l[4] : ^m ^ !l[4]);
            e = e | 12'h1 << (nb - 1);
            wr(8'h0c, l);
            wr(8'h00, m);
            u_ulmcs_peer.grab(f, nb);
            chk(f, e);
        end
        $display("tx done");
        wr(8'h0c, 8'h1b);
        u_ulmcs_peer.send(12'h402, 11);
        rdc(8'h14, 8'h65);
        rdc(8'h14, 8'h61);
        rdc(8'h00, 8'h01);
        rdc(8'h14, 8'h60);
        u_ulmcs_peer.send(12'h602, 11);
        u_ulmcs_peer.send(12'h604, 11);
        rdc(8'h14, 8'h63);
        rdc(8'h14, 8'h61);
        rdc(8'h00, 8'h02);
        $display("rx done");
        wr(8'h10, 8'h10);
        wr(8'h00, 8'h5a);
        chk({txd, td_n, rq_n}, 12'h7);
        q = 8'h00;
        for (int i = 0; i < 150 && q[0] !== 1'b1; i++) bus(8'h14, 1'b0, 8'h00);
        rdc(8'h00, 8'h5a);
        $display("loop done");
        close_out();
    end
endmodule // test_ulmcs_top
